// File: pkg/dbts_pkg.sv
package dbts_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_ERR = 3'h1;
  localparam logic [2:0] A_SCNT = 3'h2;
  localparam logic [2:0] A_ADDR_LO = 3'h3;
  localparam logic [2:0] A_ADDR_HI = 3'h4;
  localparam logic [2:0] A_ALT = 3'h6;
  localparam logic [2:0] A_CMD = 3'h7;
  // Command codes; the sector write code spans long and retry bits
  localparam logic [7:0] C_RD_MULT = 8'hc4;
  localparam logic [7:0] C_WR_MULT = 8'hc5;
  localparam logic [7:0] C_SET_MULT = 8'hc6;
  localparam logic [7:0] C_WR_SECT = 8'h30;
  localparam logic [7:0] C_WR_SECT_MASK = 8'hfc;
  localparam int LONG_BIT = 1;
  localparam logic [7:0] C_WR_VFY = 8'h3c;
  localparam logic [7:0] C_WR_BUF = 8'he8;
  localparam logic [7:0] C_WR_DMA = 8'hca;
  // Status and error bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int ER_DATA = 6;
  // Sizes and reset values
  localparam logic [7:0] LAST_WORD = 8'hff;
  localparam logic [8:0] CNT_ZERO_MEANS = 9'h100;
  localparam logic [4:0] BLK_SINGLE = 5'h01;
  localparam logic [4:0] BLK_RST = 5'h00;
  localparam logic [15:0] ADDR_RST = 16'h0001;
  localparam logic [7:0] SCNT_RST = 8'h01;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_BUSY1 = 7'h02,
    S_HOSTW = 7'h04,
    S_DISKW = 7'h08,
    S_DISKR = 7'h10,
    S_HOSTR = 7'h20,
    S_BUFF = 7'h40
  } dbts_state_e;

  typedef struct packed {
    dbts_state_e st;
    logic busy;
    logic data_request_flag;
    logic err;
    logic [7:0] err_reg;
    logic irq;
    logic dmarq;
    logic mult_en;
    logic [4:0] blk_size;
    logic [7:0] scnt;
    logic [15:0] addr;
    logic [8:0] remain;
    logic [4:0] blk_left;
    logic [4:0] blk_n;
    logic [7:0] word_cnt;
    logic blk_err;
    logic is_write;
    logic is_mult;
    logic is_dma;
    logic is_vfy;
    logic is_long;
    logic is_cfg;
    logic is_buf;
    logic disk_req;
    logic [15:0] rdata;
    logic [15:0] wdata;
    logic wvld;
  } dbts_s;
endpackage

// File: rtl/dbts_seq.sv
`timescale 1ns/10ps
module dbts_seq
  import dbts_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Host handshake
  output logic IRQ,
  output logic DMARQ,
  // Disk engine
  output logic DISK_REQ,
  output logic DISK_WRITE,
  output logic DISK_VERIFY,
  output logic DISK_LONG,
  output logic [15:0] DISK_ADDR,
  output logic [15:0] DISK_WDATA,
  output logic DISK_WVLD,
  input wire logic DISK_DONE,
  input wire logic DISK_ERR,
  input wire logic [15:0] DISK_RWORD
);
  dbts_s s;
  dbts_s n;
  logic irq_set;
  logic irq_clr;

  function automatic logic [15:0] stat_word(input dbts_s v);
    logic [15:0] w;
    w = '0;
    w[ST_BUSY] = v.busy;
    w[ST_DRQ] = v.data_request_flag;
    w[ST_ERR] = v.err;
    return w;
  endfunction

  // Length of the next block: full size, or what is left
  function automatic logic [4:0] blen(input logic [8:0] rem, input logic [4:0] sz);
    if (rem < {4'h0, sz})
    begin
      return rem[4:0];
    end
    return sz;
  endfunction

  // Single-sector commands must not disturb the stored block size
  function automatic logic [4:0] cur_size(input dbts_s v);
    return v.is_mult ? v.blk_size : BLK_SINGLE;
  endfunction

  function automatic logic [8:0] cnt_total(input logic [7:0] c);
    if (c == 8'h00)
    begin
      return CNT_ZERO_MEANS;
    end
    return {1'b0, c};
  endfunction

  always_comb
  begin
    n = s;
    irq_set = 1'b0;
    irq_clr = 1'b0;
    n.rdata = '0;
    n.disk_req = 1'b0;
    n.wvld = 1'b0;
    if (RD)
    begin
      unique case (ADDR)
        A_DATA: n.rdata = DISK_RWORD;
        A_ERR: n.rdata = {8'h00, s.err_reg};
        A_SCNT: n.rdata = {8'h00, s.scnt};
        A_ADDR_LO: n.rdata = {8'h00, s.addr[7:0]};
        A_ADDR_HI: n.rdata = {8'h00, s.addr[15:8]};
        A_ALT: n.rdata = stat_word(s);
        A_CMD:
        begin
          n.rdata = stat_word(s);
          irq_clr = 1'b1;
        end
        default: n.rdata = '0;
      endcase
    end
    if (WR && s.st == S_IDLE && ADDR == A_SCNT)
    begin
      n.scnt = WDATA[7:0];
    end
    if (WR && s.st == S_IDLE && ADDR == A_ADDR_LO)
    begin
      n.addr[7:0] = WDATA[7:0];
    end
    if (WR && s.st == S_IDLE && ADDR == A_ADDR_HI)
    begin
      n.addr[15:8] = WDATA[7:0];
    end
    if (WR && ADDR == A_CMD)
    begin
      irq_clr = 1'b1;
    end
    unique case (s.st)
      S_IDLE:
      begin
        if (WR && ADDR == A_CMD)
        begin
          n.err = 1'b0;
          n.err_reg = '0;
          n.busy = 1'b1;
          n.blk_err = 1'b0;
          n.word_cnt = '0;
          n.is_write = 1'b0;
          n.is_mult = 1'b0;
          n.is_dma = 1'b0;
          n.is_vfy = 1'b0;
          n.is_long = 1'b0;
          n.is_cfg = 1'b0;
          n.is_buf = 1'b0;
          n.remain = cnt_total(s.scnt);
          if (WDATA[7:0] == C_SET_MULT)
          begin
            n.is_cfg = 1'b1;
            n.st = S_BUSY1;
          end
          else if (WDATA[7:0] == C_RD_MULT || WDATA[7:0] == C_WR_MULT)
          begin
            // Size and enable are consulted by every block command
            if (!s.mult_en)
            begin
              n.err = 1'b1;
              n.err_reg[ER_ABRT] = 1'b1;
              n.busy = 1'b0;
              irq_set = 1'b1;
            end
            else if (WDATA[7:0] == C_RD_MULT)
            begin
              n.is_mult = 1'b1;
              n.blk_left = blen(n.remain, s.blk_size);
              n.blk_n = n.blk_left;
              n.disk_req = 1'b1;
              n.st = S_DISKR;
            end
            else
            begin
              // Long and retry bits have no meaning here
              n.is_mult = 1'b1;
              n.is_write = 1'b1;
              n.st = S_BUSY1;
            end
          end
          else if ((WDATA[7:0] & C_WR_SECT_MASK) == C_WR_SECT ||
                   WDATA[7:0] == C_WR_VFY || WDATA[7:0] == C_WR_DMA)
          begin
            n.is_write = 1'b1;
            n.is_vfy = (WDATA[7:0] == C_WR_VFY);
            n.is_dma = (WDATA[7:0] == C_WR_DMA);
            n.is_long = ((WDATA[7:0] & C_WR_SECT_MASK) == C_WR_SECT) &&
                        WDATA[LONG_BIT];
            n.blk_left = BLK_SINGLE;
            n.busy = 1'b0;
            n.data_request_flag = 1'b1;
            n.st = S_HOSTW;
          end
          else if (WDATA[7:0] == C_WR_BUF)
          begin
            n.is_buf = 1'b1;
            n.st = S_BUSY1;
          end
          else
          begin
            n.err = 1'b1;
            n.err_reg[ER_ABRT] = 1'b1;
            n.busy = 1'b0;
            irq_set = 1'b1;
          end
        end
      end
      S_BUSY1:
      begin
        n.busy = 1'b0;
        irq_set = 1'b1;
        n.st = S_IDLE;
        if (s.is_cfg)
        begin
          unique case (s.scnt)
            8'h00: n.mult_en = 1'b0;
            8'h02, 8'h04, 8'h08, 8'h10:
            begin
              n.blk_size = s.scnt[4:0];
              n.mult_en = 1'b1;
            end
            default:
            begin
              n.mult_en = 1'b0;
              n.err = 1'b1;
              n.err_reg[ER_ABRT] = 1'b1;
            end
          endcase
        end
        else if (s.is_buf)
        begin
          n.data_request_flag = 1'b1;
          n.word_cnt = '0;
          n.st = S_BUFF;
        end
        else
        begin
          n.data_request_flag = 1'b1;
          n.blk_left = blen(s.remain, s.blk_size);
          n.st = S_HOSTW;
        end
      end
      S_HOSTW:
      begin
        if (WR && ADDR == A_DATA)
        begin
          n.wdata = WDATA;
          n.wvld = 1'b1;
          n.word_cnt = s.word_cnt + 8'h01;
          if (s.word_cnt == LAST_WORD)
          begin
            if (s.blk_left == 5'h01)
            begin
              // Whole block is in; the engine seeks on its own if needed
              n.data_request_flag = 1'b0;
              n.busy = 1'b1;
              n.disk_req = 1'b1;
              n.blk_left = blen(s.remain, cur_size(s));
              n.st = S_DISKW;
            end
            else
            begin
              n.blk_left = s.blk_left - 5'h01;
            end
          end
        end
      end
      S_DISKW:
      begin
        if (DISK_DONE)
        begin
          if (DISK_ERR)
          begin
            // Address still names the failing sector
            n.err = 1'b1;
            n.err_reg[ER_DATA] = 1'b1;
            n.busy = 1'b0;
            irq_set = 1'b1;
            n.st = S_IDLE;
          end
          else if (s.remain == 9'h001)
          begin
            n.remain = '0;
            n.busy = 1'b0;
            irq_set = 1'b1;
            n.st = S_IDLE;
          end
          else
          begin
            n.remain = s.remain - 9'h001;
            n.addr = s.addr + 16'h0001;
            if (s.blk_left == 5'h01)
            begin
              n.busy = 1'b0;
              n.data_request_flag = 1'b1;
              irq_set = !s.is_dma;
              n.blk_left = blen(n.remain, cur_size(s));
              n.st = S_HOSTW;
            end
            else
            begin
              n.blk_left = s.blk_left - 5'h01;
              n.disk_req = 1'b1;
            end
          end
        end
      end
      S_DISKR:
      begin
        if (DISK_DONE)
        begin
          n.remain = s.remain - 9'h001;
          n.blk_err = s.blk_err | DISK_ERR;
          if (!n.blk_err && n.remain != '0)
          begin
            n.addr = s.addr + 16'h0001;
          end
          if (s.blk_left == 5'h01)
          begin
            // Error shows at block start, data still handed over
            n.err = n.blk_err;
            n.err_reg[ER_DATA] = n.blk_err;
            n.busy = 1'b0;
            n.data_request_flag = 1'b1;
            irq_set = 1'b1;
            n.blk_left = s.blk_n;
            n.word_cnt = '0;
            n.st = S_HOSTR;
          end
          else
          begin
            n.blk_left = s.blk_left - 5'h01;
            n.disk_req = 1'b1;
          end
        end
      end
      S_HOSTR:
      begin
        if (RD && ADDR == A_DATA)
        begin
          n.word_cnt = s.word_cnt + 8'h01;
          if (s.word_cnt == LAST_WORD)
          begin
            if (s.blk_left == 5'h01)
            begin
              n.data_request_flag = 1'b0;
              if (s.remain == '0 || s.blk_err)
              begin
                n.st = S_IDLE;
              end
              else
              begin
                n.busy = 1'b1;
                n.blk_left = blen(s.remain, s.blk_size);
                n.blk_n = n.blk_left;
                n.disk_req = 1'b1;
                n.st = S_DISKR;
              end
            end
            else
            begin
              n.blk_left = s.blk_left - 5'h01;
            end
          end
        end
      end
      S_BUFF:
      begin
        if (WR && ADDR == A_DATA)
        begin
          n.wdata = WDATA;
          n.wvld = 1'b1;
          n.word_cnt = s.word_cnt + 8'h01;
          if (s.word_cnt == LAST_WORD)
          begin
            n.data_request_flag = 1'b0;
            n.st = S_IDLE;
          end
        end
      end
    endcase
    // A new event outranks a clear in the same cycle
    n.irq = (s.irq & ~irq_clr) | irq_set;
    n.dmarq = n.data_request_flag & n.is_dma;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      s <= '0;
      s.st <= S_IDLE;
      s.mult_en <= 1'b0;
      s.blk_size <= BLK_RST;
      s.scnt <= SCNT_RST;
      s.addr <= ADDR_RST;
    end
    else
    begin
      s <= n;
    end
  end

  assign RDATA = s.rdata;
  assign IRQ = s.irq;
  assign DMARQ = s.dmarq;
  assign DISK_REQ = s.disk_req;
  assign DISK_WRITE = s.is_write;
  assign DISK_VERIFY = s.is_vfy;
  assign DISK_LONG = s.is_long;
  assign DISK_ADDR = s.addr;
  assign DISK_WDATA = s.wdata;
  assign DISK_WVLD = s.wvld;

  wire cmd_wr = WR && ADDR == A_CMD && s.st == S_IDLE;

  property p_irq_clr;
    @(posedge REF_CLK) disable iff (RST)
    RD && ADDR == A_CMD && s.st == S_IDLE |=> !IRQ;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq not dropped");

  property p_cfg_zero;
    @(posedge REF_CLK) disable iff (RST)
    cmd_wr && WDATA[7:0] == C_SET_MULT && s.scnt == 8'h00
    |=> s.busy ##1 (!s.mult_en && IRQ && !s.err && !s.busy);
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("zero size");

  property p_cfg_ok;
    @(posedge REF_CLK) disable iff (RST)
    cmd_wr && WDATA[7:0] == C_SET_MULT && s.scnt == 8'h04
    |-> ##2 (s.mult_en && s.blk_size == 5'h04 && !s.err);
  endproperty
  a_cfg_ok: assert property (p_cfg_ok) else $error("size not stored");

  property p_cfg_bad;
    @(posedge REF_CLK) disable iff (RST)
    cmd_wr && WDATA[7:0] == C_SET_MULT && s.scnt == 8'h03
    |-> ##2 (!s.mult_en && s.err_reg[ER_ABRT]);
  endproperty
  a_cfg_bad: assert property (p_cfg_bad) else $error("bad size kept");

  property p_abort;
    @(posedge REF_CLK) disable iff (RST)
    cmd_wr && (WDATA[7:0] == C_RD_MULT || WDATA[7:0] == C_WR_MULT) && !s.mult_en
    |=> s.err_reg[ER_ABRT] && IRQ && s.st == S_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");

  property p_wsect;
    @(posedge REF_CLK) disable iff (RST)
    cmd_wr && (WDATA[7:0] & C_WR_SECT_MASK) == C_WR_SECT |=> s.data_request_flag && !IRQ && !s.busy;
  endproperty
  a_wsect: assert property (p_wsect) else $error("first fill wrong");

  property p_wmult;
    @(posedge REF_CLK) disable iff (RST)
    cmd_wr && WDATA[7:0] == C_WR_MULT && s.mult_en
    |=> (s.busy && !s.data_request_flag) ##1 (s.data_request_flag && IRQ);
  endproperty
  a_wmult: assert property (p_wmult) else $error("block write start");

  property p_rd_noirq;
    @(posedge REF_CLK) disable iff (RST)
    s.st == S_HOSTR |=> !$rose(IRQ);
  endproperty
  a_rd_noirq: assert property (p_rd_noirq) else $error("irq inside block");

  property p_fill;
    @(posedge REF_CLK) disable iff (RST)
    s.st == S_HOSTW && WR && ADDR == A_DATA && s.word_cnt == LAST_WORD && s.blk_left == 5'h01
    |=> !s.data_request_flag && s.busy && DISK_REQ;
  endproperty
  a_fill: assert property (p_fill) else $error("buffer full not handled");

  property p_dma;
    @(posedge REF_CLK) disable iff (RST)
    s.is_dma && s.st != S_IDLE |-> !IRQ;
  endproperty
  a_dma: assert property (p_dma) else $error("dma mid irq");

  c_rd_err: cover property (@(posedge REF_CLK) disable iff (RST)
    s.st == S_DISKR ##1 s.st == S_HOSTR && s.err);
  c_wmult_done: cover property (@(posedge REF_CLK) disable iff (RST)
    s.is_mult && s.is_write && s.st == S_DISKW ##1 s.st == S_IDLE && !s.err);
  c_buf: cover property (@(posedge REF_CLK) disable iff (RST)
    s.st == S_BUFF ##1 s.st == S_IDLE);
endmodule

// File: tb/dbts_disk_model.sv
`timescale 1ns/10ps
// Behavioural disk engine; each sector finishes a fixed time after its start
module dbts_disk_model #(
  parameter int DELAY = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sector start from the sequencer
  input wire logic req,
  input wire logic [15:0] sect,
  // Fault injection from the bench
  input wire logic err_en,
  input wire logic [15:0] err_at,
  // Sector result
  output logic done,
  output logic err,
  output logic [15:0] rword
);
  logic busy_r;
  logic [7:0] cnt_r;
  logic [15:0] tgt_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      tgt_r <= 16'h0000;
      done <= 1'b0;
      err <= 1'b0;
      rword <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      // Error and read word mean nothing outside done, so they keep moving
      err <= ~err;
      rword <= rword + 16'h3c5b;
      if (req)
      begin
        // The engine seeks by itself before every sector
        busy_r <= 1'b1;
        cnt_r <= DELAY[7:0];
        tgt_r <= sect;
      end
      else if (busy_r && cnt_r == 8'h00)
      begin
        busy_r <= 1'b0;
        done <= 1'b1;
        err <= err_en && tgt_r == err_at;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// File: tb/dbts_seq_bench.sv
`timescale 1ns/10ps
module dbts_seq_bench;
  import dbts_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic irq, dmarq, d_req, d_write, d_verify, d_long, d_wvld, d_done, d_err;
  logic [15:0] d_addr, d_wdata, d_rword;
  logic err_en = 1'b0;
  logic [15:0] err_at = 16'h0000;
  logic irq_q = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  int req_cnt = 0;
  int wvld_cnt = 0;
  int irq_rise = 0;

  dbts_seq i_dut (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .DMARQ(dmarq), .DISK_REQ(d_req), .DISK_WRITE(d_write),
    .DISK_VERIFY(d_verify), .DISK_LONG(d_long), .DISK_ADDR(d_addr), .DISK_WDATA(d_wdata),
    .DISK_WVLD(d_wvld), .DISK_DONE(d_done), .DISK_ERR(d_err), .DISK_RWORD(d_rword));

  dbts_disk_model i_disk (.clk(ref_clk), .rst(rst), .req(d_req), .sect(d_addr),
    .err_en(err_en), .err_at(err_at), .done(d_done), .err(d_err), .rword(d_rword));

  always #5 ref_clk = ~ref_clk;

  // Event counters sample the previous cycle's registered outputs
  always @(posedge ref_clk)
  begin
    if (d_req === 1'b1)
      req_cnt++;
    if (d_wvld === 1'b1)
      wvld_cnt++;
    if (irq === 1'b1 && irq_q !== 1'b1)
      irq_rise++;
    irq_q = irq;
  end

  function automatic logic [15:0] b1(input logic x);
    return {15'h0000, x};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Polls alternate status so that a pending interrupt survives the wait
  task automatic wait_st(input logic want_drq, output logic [15:0] st);
    int n;
    n = 0;
    st = 16'h0080;
    while (n < 400 && !(st[ST_BUSY] === 1'b0 && st[ST_DRQ] === want_drq))
    begin
      rd_reg(A_ALT, st);
      n++;
    end
    check({14'h0, st[ST_BUSY], st[ST_DRQ]}, {15'h0, want_drq}, "status wait");
  endtask

  task automatic fill(input int n);
    for (int i = 0; i < n; i++)
      wr_reg(A_DATA, 16'ha500 + i[15:0]);
    #1;
    check(d_wdata, 16'ha500 + 16'(n - 1), "last word stored");
  endtask

  task automatic cmd(input logic [7:0] cnt, input logic [15:0] a, input logic [7:0] code);
    wr_reg(A_SCNT, {8'h00, cnt});
    wr_reg(A_ADDR_LO, {8'h00, a[7:0]});
    wr_reg(A_ADDR_HI, {8'h00, a[15:8]});
    wr_reg(A_CMD, {8'h00, code});
  endtask

  task automatic t_abort(input string what);
    logic [15:0] st;
    wr_reg(A_CMD, {8'h00, C_WR_MULT});
    wait_st(1'b0, st);
    check(b1(st[ST_ERR]), 16'h0001, what);
    rd_reg(A_ERR, st);
    check(b1(st[ER_ABRT]), 16'h0001, "abort code");
    rd_reg(A_CMD, st);
    check(b1(irq), 16'h0000, "irq after status read");
  endtask

  task automatic t_cfg;
    logic [7:0] sz [6] = '{8'h00, 8'h03, 8'h04, 8'h08, 8'h10, 8'h02};
    logic [15:0] st;
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(A_SCNT, {8'h00, sz[i]});
      wr_reg(A_CMD, {8'h00, C_SET_MULT});
      wait_st(1'b0, st);
      check(b1(irq), 16'h0001, "config irq");
      check(b1(st[ST_ERR]), b1(sz[i] == 8'h03), "config error");
      rd_reg(A_CMD, st);
      if (i < 2)
        t_abort("block write while disabled");
    end
  endtask

  task automatic t_blkwr;
    logic [15:0] st;
    int r0, w0, i0;
    r0 = req_cnt;
    w0 = wvld_cnt;
    i0 = irq_rise;
    cmd(8'h03, 16'h0010, C_WR_MULT);
    for (int b = 0; b < 2; b++)
    begin
      wait_st(1'b1, st);
      check(b1(irq), 16'h0001, "block start irq");
      rd_reg(A_CMD, st);
      fill(b == 0 ? 512 : 256);
    end
    wait_st(1'b0, st);
    check(b1(d_write), 16'h0001, "write level");
    check(16'(req_cnt - r0), 16'h0003, "sectors moved");
    check(16'(wvld_cnt - w0), 16'h0300, "words moved");
    check(16'(irq_rise - i0), 16'h0003, "interrupts");
    check(d_addr, 16'h0012, "last sector");
  endtask

  task automatic t_secwr;
    logic [15:0] st;
    int r0;
    r0 = req_cnt;
    cmd(8'h02, 16'h0020, C_WR_SECT | 8'h02);
    wait_st(1'b1, st);
    check(b1(irq), 16'h0000, "first fill irq");
    check(b1(d_long), 16'h0001, "long level");
    fill(256);
    rd_reg(A_ALT, st);
    check({14'h0, st[ST_BUSY], st[ST_DRQ]}, 16'h0002, "busy after fill");
    wait_st(1'b1, st);
    check(b1(irq), 16'h0001, "next fill irq");
    rd_reg(A_CMD, st);
    fill(256);
    wait_st(1'b0, st);
    check(b1(irq), 16'h0001, "end irq");
    check(d_addr, 16'h0021, "last sector");
    check(16'(req_cnt - r0), 16'h0002, "sectors written");
  endtask

  task automatic t_vfyerr;
    logic [15:0] st;
    int r0;
    r0 = req_cnt;
    err_en <= 1'b1;
    err_at <= 16'h0031;
    cmd(8'h03, 16'h0030, C_WR_VFY);
    wait_st(1'b1, st);
    check(b1(d_verify), 16'h0001, "verify level");
    check(b1(d_long), 16'h0000, "no long on verify");
    fill(256);
    wait_st(1'b1, st);
    rd_reg(A_CMD, st);
    fill(256);
    wait_st(1'b0, st);
    check(b1(st[ST_ERR]), 16'h0001, "write error");
    rd_reg(A_ERR, st);
    check(b1(st[ER_DATA]), 16'h0001, "data error code");
    check(d_addr, 16'h0031, "failing sector");
    check(16'(req_cnt - r0), 16'h0002, "stopped at error");
    err_en <= 1'b0;
    rd_reg(A_CMD, st);
  endtask

  task automatic t_buf;
    logic [15:0] st;
    int r0;
    r0 = req_cnt;
    wr_reg(A_CMD, {8'h00, C_WR_BUF});
    wait_st(1'b1, st);
    check(b1(irq), 16'h0001, "buffer irq");
    rd_reg(A_CMD, st);
    fill(255);
    rd_reg(A_ALT, st);
    check(b1(st[ST_DRQ]), 16'h0001, "one word left");
    fill(1);
    wait_st(1'b0, st);
    check(16'(req_cnt - r0), 16'h0000, "no disk work");
  endtask

  task automatic t_dma;
    logic [15:0] st;
    int r0, i0, n;
    r0 = req_cnt;
    i0 = irq_rise;
    cmd(8'h02, 16'h0040, C_WR_DMA);
    for (int s = 0; s < 2; s++)
    begin
      n = 0;
      while (n < 400 && dmarq !== 1'b1)
      begin
        @(posedge ref_clk);
        n++;
      end
      check(b1(dmarq), 16'h0001, "dma request");
      // Host owns and drives every data word of the burst
      fill(256);
    end
    wait_st(1'b0, st);
    check(16'(irq_rise - i0), 16'h0001, "single dma irq");
    check(16'(req_cnt - r0), 16'h0002, "dma sectors");
    rd_reg(A_CMD, st);
  endtask

  // Runs after sector writes, so a lost block size shows up here
  task automatic t_blkrd;
    logic [15:0] st;
    int r0, i0;
    r0 = req_cnt;
    i0 = irq_rise;
    err_en <= 1'b1;
    err_at <= 16'h0051;
    cmd(8'h03, 16'h0050, C_RD_MULT);
    wait_st(1'b1, st);
    check(b1(st[ST_ERR]), 16'h0001, "error at block start");
    check(16'(req_cnt - r0), 16'h0002, "whole block read first");
    rd_reg(A_CMD, st);
    for (int i = 0; i < 511; i++)
      rd_reg(A_DATA, st);
    rd_reg(A_ALT, st);
    check(b1(st[ST_DRQ]), 16'h0001, "request held through block");
    rd_reg(A_DATA, st);
    wait_st(1'b0, st);
    check(16'(irq_rise - i0), 16'h0001, "one irq per block");
    check(d_addr, 16'h0051, "failing read sector");
    check(16'(req_cnt - r0), 16'h0002, "no block after error");
    err_en <= 1'b0;
  endtask

  task automatic t_rst2;
    logic [15:0] st;
    wr_reg(A_SCNT, 16'h0004);
    wr_reg(A_CMD, {8'h00, C_SET_MULT});
    wait_st(1'b0, st);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check(b1(irq), 16'h0000, "irq after reset");
    t_abort("block write after reset");
  endtask

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_abort("block write before config");
    t_cfg();
    t_blkwr();
    t_secwr();
    t_vfyerr();
    t_buf();
    t_dma();
    t_blkrd();
    t_rst2();
    end_sim();
  end

  // The whole run needs well under 20000 cycles
  initial
  begin
    #500000;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
